/* File: rtl/rsc_pkg.sv */
// Constants, types and register map of the reset source controller.
// Assumes a 16-bit register port and reset sources that are synchronous levels.
package rsc_pkg;

    localparam int DW   = 16;
    localparam int AW   = 4;
    localparam int NSRC = 9;

    // Bit position of each source in the reset status register.
    localparam int SRC_POR   = 0;
    localparam int SRC_BOR   = 1;
    localparam int SRC_SWR   = 2;
    localparam int SRC_WDT   = 3;
    localparam int SRC_PIN   = 4;
    localparam int SRC_LPBOR = 5;
    localparam int SRC_TRAP  = 6;
    localparam int SRC_IOP   = 7;
    localparam int SRC_UWR   = 8;

    // Register word offsets.
    localparam logic [AW-1:0] ADDR_RCS     = 4'h0;
    localparam logic [AW-1:0] ADDR_OSC     = 4'h1;
    localparam logic [AW-1:0] ADDR_RTC     = 4'h2;
    localparam logic [AW-1:0] ADDR_NVM     = 4'h3;
    localparam logic [AW-1:0] ADDR_GEN     = 4'h4;
    localparam logic [AW-1:0] ADDR_SCRATCH = 4'h5;
    localparam logic [AW-1:0] ADDR_IRQ_ST  = 4'h6;
    localparam logic [AW-1:0] ADDR_IRQ_MSK = 4'h7;
    localparam logic [AW-1:0] ADDR_SEQ     = 4'h8;

    // Values after reset.
    localparam logic [DW-1:0] RCS_POR_VAL = 16'h0003;
    localparam logic [DW-1:0] RCS_RST_VAL = 16'h0003;
    localparam logic [DW-1:0] GEN_RST_VAL = 16'h0000;
    localparam logic [DW-1:0] RTC_RST_VAL = 16'h0000;
    localparam logic [DW-1:0] NVM_RST_VAL = 16'h0000;
    localparam logic [DW-1:0] OSC_RST_VAL = 16'h0000;
    localparam logic [DW-1:0] ZERO_W      = 16'h0000;

    // Oscillator control field layout.
    localparam int         OSC_NEW_LSB    = 0;
    localparam int         OSC_CUR_LSB    = 4;
    localparam int         OSC_FAIL_BIT   = 8;
    localparam int         OSC_SWITCH_BIT = 15;
    localparam logic [2:0] OSC_FRC        = 3'h0;

    // Interrupt status and mask layout.
    localparam int IRQ_W        = 2;
    localparam int IRQ_CLK_FAIL = 0;
    localparam int IRQ_RST_DONE = 1;

    typedef struct packed {
        logic uninit_wreg_reset;
        logic iop;
        logic trap;
        logic lpbor;
        logic pin;
        logic wdt;
        logic software_reset_instr;
        logic bor;
        logic por;
    } rsc_src_t;

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } rsc_bus_req_t;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_WAIT_CLK,
        ST_RUN
    } rsc_state_t;

endpackage : rsc_pkg

/* File: rtl/rsc_top.sv */
// Reset source controller: merges reset sources, records the cause and sequences code start.
// Assumes all inputs are synchronous to i_clk and i_reset is the controller's own power reset.
//
// Functional notes
// [R1] All nine reset sources feed one controller.
// [R2] System reset held while any source active.
// [R3] Each reset sets its own status flag.
// [R4] Power-on sets bits 1:0, clears others.
// [R5] Software may set or clear flags anytime. Here an active source's flag stays set; writes during power-on are lost.
// [R6] Software flag writes never cause a reset.
// [R7] Software should clear flags after reading them.
// [R8] Clock start-up independent of reset release.
// [R9] No execution until valid clock released.
// [R10] Clock monitoring starts at reset release.
// [R11] No clock at release: switch RC, trap.
// [R12] Unforced registers keep contents through resets.
// [R13] Ordinary registers take one fixed reset value.
// [R14] Status register reset value follows reset type.
// [R15] Oscillator control reset follows type and config.
// [R16] RTC and NVM control reset only by power-on.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps

module rsc_top
    import rsc_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire rsc_src_t     i_src,
    input  wire logic         i_clk_valid,
    input  wire logic         i_clock_fail_monitor_enable,
    input  wire logic [2:0]   i_initial_osc_select,
    input  wire rsc_bus_req_t i_bus,
    output logic              o_system_reset,
    output logic              o_run,
    output logic              o_trap,
    output logic [2:0]        o_osc_cur,
    output logic              o_irq,
    output logic [DW-1:0]     o_rdata
);

    rsc_state_t       state_q;
    rsc_state_t       state_d;
    logic             sys_rst_q;
    logic             run_q;
    logic             trap_q;
    logic             irq_q;
    logic [DW-1:0]    rdata_q;
    logic [DW-1:0]    rcs_q;
    logic [DW-1:0]    rcs_d;
    logic [DW-1:0]    osc_q;
    logic [DW-1:0]    osc_d;
    logic [DW-1:0]    rtc_q;
    logic [DW-1:0]    nvm_q;
    logic [DW-1:0]    gen_q;
    logic [DW-1:0]    scratch_q;
    logic [IRQ_W-1:0] ist_q;
    logic [IRQ_W-1:0] ist_d;
    logic [IRQ_W-1:0] msk_q;
    logic [IRQ_W-1:0] msk_d;

    // Address decode.
    wire logic wr_rcs     = i_bus.wr && (i_bus.addr == ADDR_RCS);
    wire logic wr_osc     = i_bus.wr && (i_bus.addr == ADDR_OSC);
    wire logic wr_rtc     = i_bus.wr && (i_bus.addr == ADDR_RTC);
    wire logic wr_nvm     = i_bus.wr && (i_bus.addr == ADDR_NVM);
    wire logic wr_gen     = i_bus.wr && (i_bus.addr == ADDR_GEN);
    wire logic wr_scratch = i_bus.wr && (i_bus.addr == ADDR_SCRATCH);
    wire logic wr_ist     = i_bus.wr && (i_bus.addr == ADDR_IRQ_ST);
    wire logic wr_msk     = i_bus.wr && (i_bus.addr == ADDR_IRQ_MSK);

    // Every source reaches the master reset; nothing here looks at the clock, so release
    // may come before the oscillator has started.
    wire logic          src_any  = |i_src;                          // [R1] [R2] [R8]
    wire logic [DW-1:0] src_bits = {{(DW-NSRC){1'b0}}, i_src};      // [R1]

    wire logic [2:0] osc_cur  = osc_q[OSC_CUR_LSB +: 3];
    wire logic       clk_ok   = i_clk_valid || (osc_cur == OSC_FRC);
    wire logic       released = (state_q == ST_RESET) && !sys_rst_q;

    // A missing clock at release, or a later loss while running, forces the internal RC.
    wire logic fail_evt = i_clock_fail_monitor_enable && !clk_ok && !sys_rst_q &&
                          ((state_q == ST_RESET) || (state_q == ST_RUN));      // [R10] [R11]

    // Status flags: a source that is active wins over a software write in the same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < DW; gi++) begin : g_rcs
            wire logic sw_val = wr_rcs ? i_bus.wdata[gi] : rcs_q[gi];       // [R5] [R6]
            assign rcs_d[gi] = i_src.por ? RCS_POR_VAL[gi]                  // [R4] [R14]
                                         : (sw_val | src_bits[gi]);         // [R3] [R14]
        end
    endgenerate

    // Oscillator control: power-on loads both selections from the configuration word, any
    // other reset reloads only the requested selection and keeps the running one.
    always_comb begin
        osc_d = osc_q;
        if (i_src.por) begin                                                // [R15]
            osc_d                         = OSC_RST_VAL;
            osc_d[OSC_NEW_LSB +: 3]       = i_initial_osc_select;
            osc_d[OSC_CUR_LSB +: 3]       = i_initial_osc_select;
        end else if (src_any) begin                                         // [R15]
            osc_d[OSC_NEW_LSB +: 3]       = i_initial_osc_select;
        end else if (fail_evt) begin                                        // [R11]
            osc_d[OSC_CUR_LSB +: 3]       = OSC_FRC;
            osc_d[OSC_FAIL_BIT]           = 1'b1;
        end else if (wr_osc) begin
            osc_d[OSC_NEW_LSB +: 3]       = i_bus.wdata[OSC_NEW_LSB +: 3];
            osc_d[OSC_FAIL_BIT]           = i_bus.wdata[OSC_FAIL_BIT];
            if (i_bus.wdata[OSC_SWITCH_BIT]) begin
                osc_d[OSC_CUR_LSB +: 3]   = i_bus.wdata[OSC_NEW_LSB +: 3];
            end
        end
    end

    // Sequencer: code starts once a usable clock is there or the clock-fail monitor is enabled.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                if (released) begin
                    if (clk_ok || i_clock_fail_monitor_enable) begin                      // [R9] [R10]
                        state_d = ST_RUN;
                    end else begin
                        state_d = ST_WAIT_CLK;
                    end
                end
            end
            ST_WAIT_CLK: begin
                if (clk_ok || i_clock_fail_monitor_enable) begin                          // [R9]
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
        if (sys_rst_q) begin
            state_d = ST_RESET;
        end
    end

    // Interrupt status is write-one-to-clear; a new event wins over the clear.
    wire logic [IRQ_W-1:0] evt     = {released, fail_evt};
    wire logic [IRQ_W-1:0] ist_clr = wr_ist ? i_bus.wdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
    assign ist_d = (ist_q & ~ist_clr) | evt;
    assign msk_d = wr_msk ? i_bus.wdata[IRQ_W-1:0] : msk_q;

    // Read mux; unmapped offsets read zero.
    wire logic [DW-1:0] seq_word = {{(DW-4){1'b0}}, run_q, i_clk_valid, state_q};
    wire logic [DW-1:0] rd_mux =
        (i_bus.addr == ADDR_RCS)     ? rcs_q :
        (i_bus.addr == ADDR_OSC)     ? osc_q :
        (i_bus.addr == ADDR_RTC)     ? rtc_q :
        (i_bus.addr == ADDR_NVM)     ? nvm_q :
        (i_bus.addr == ADDR_GEN)     ? gen_q :
        (i_bus.addr == ADDR_SCRATCH) ? scratch_q :
        (i_bus.addr == ADDR_IRQ_ST)  ? {{(DW-IRQ_W){1'b0}}, ist_q} :
        (i_bus.addr == ADDR_IRQ_MSK) ? {{(DW-IRQ_W){1'b0}}, msk_q} :
        (i_bus.addr == ADDR_SEQ)     ? seq_word : ZERO_W;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q   <= ST_RESET;
            sys_rst_q <= 1'b1;
            run_q     <= 1'b0;
            trap_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            sys_rst_q <= src_any;                                           // [R2]
            run_q     <= (state_d == ST_RUN);                               // [R9]
            trap_q    <= fail_evt;                                          // [R11]
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rcs_q <= RCS_RST_VAL;
            osc_q <= OSC_RST_VAL;
        end else begin
            rcs_q <= rcs_d;
            osc_q <= osc_d;
        end
    end

    // Only power-on clears these; other resets leave them as software left them.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rtc_q <= RTC_RST_VAL;
            nvm_q <= NVM_RST_VAL;
        end else if (i_src.por) begin                                       // [R16]
            rtc_q <= RTC_RST_VAL;
            nvm_q <= NVM_RST_VAL;
        end else begin
            rtc_q <= wr_rtc ? i_bus.wdata : rtc_q;
            nvm_q <= wr_nvm ? i_bus.wdata : nvm_q;
        end
    end

    // A forced register takes the same value for every reset type, while the scratch
    // register is never forced and so carries its contents through any reset.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            gen_q     <= GEN_RST_VAL;
            scratch_q <= ZERO_W;
        end else begin
            gen_q     <= src_any ? GEN_RST_VAL : (wr_gen ? i_bus.wdata : gen_q);     // [R13]
            scratch_q <= wr_scratch ? i_bus.wdata : scratch_q;                      // [R12]
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ist_q   <= {IRQ_W{1'b0}};
            msk_q   <= {IRQ_W{1'b0}};
            irq_q   <= 1'b0;
            rdata_q <= ZERO_W;
        end else begin
            ist_q   <= ist_d;
            msk_q   <= msk_d;
            irq_q   <= |(ist_d & msk_d);
            rdata_q <= i_bus.rd ? rd_mux : ZERO_W;
        end
    end

    assign o_system_reset = sys_rst_q;
    assign o_run          = run_q;
    assign o_trap         = trap_q;
    assign o_osc_cur      = osc_q[OSC_CUR_LSB +: 3];
    assign o_irq          = irq_q;
    assign o_rdata        = rdata_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    system_reset_out_follow_a: assert property (src_any |=> o_system_reset)                        // [R2]
        else $error("system reset not asserted after an active source");
    system_reset_out_release_a: assert property ($fell(o_system_reset) |-> !$past(src_any))         // [R2]
        else $error("system reset released while a source was active");
    por_flags_a: assert property (i_src.por |=> (rcs_q == RCS_POR_VAL))                  // [R4]
        else $error("power-on did not leave only bits 1:0 set");
    cause_flag_a: assert property ((i_src.wdt && !i_src.por) |=> rcs_q[SRC_WDT])         // [R3]
        else $error("watchdog reset flag not recorded");
    sw_flag_write_a: assert property ((wr_rcs && !src_any) |=>                            // [R5]
        (rcs_q == $past(i_bus.wdata)) && !o_system_reset)
        else $error("software flag write not stored or caused a reset");
    sw_no_reset_a: assert property ((wr_rcs && !src_any) ##1 !src_any |=> !o_system_reset) // [R6]
        else $error("flag write produced a system reset");
    run_gate_a: assert property ((state_q == ST_WAIT_CLK && !i_clk_valid && !i_clock_fail_monitor_enable
        && osc_cur != OSC_FRC) |=> !o_run)                                                // [R9]
        else $error("execution started without a valid clock");
    monitor_start_a: assert property ((released && i_clock_fail_monitor_enable) |=> o_run)              // [R10]
        else $error("monitored release did not start the core");
    frc_switch_a: assert property (fail_evt && !src_any |=> o_trap &&                     // [R11]
        (o_osc_cur == OSC_FRC) ##1 !o_trap)
        else $error("clock failure did not switch to internal RC with one trap pulse");
    rtc_hold_a: assert property ((src_any && !i_src.por && !wr_rtc && !wr_nvm) |=>       // [R16]
        $stable(rtc_q) && $stable(nvm_q))
        else $error("non power-on reset changed RTC or NVM control");
    rtc_por_clr_a: assert property (i_src.por |=> (rtc_q == RTC_RST_VAL) && (nvm_q == NVM_RST_VAL)) // [R16]
        else $error("power-on did not clear RTC or NVM control");
    gen_reset_a: assert property (src_any |=> (gen_q == GEN_RST_VAL))                    // [R13]
        else $error("forced register missed its reset value");
    scratch_hold_a: assert property ((src_any && !wr_scratch) |=> $stable(scratch_q))     // [R12]
        else $error("unforced register changed through a reset");
    osc_reset_a: assert property (i_src.por |=> (osc_q[OSC_NEW_LSB +: 3] == $past(i_initial_osc_select))   // [R15]
        && (o_osc_cur == $past(i_initial_osc_select)))
        else $error("oscillator control not loaded from configuration on power-on");
    irq_level_a: assert property (o_irq == |(ist_q & msk_q))
        else $error("interrupt output disagrees with masked status");
    read_data_a: assert property (!i_bus.rd |=> (o_rdata == ZERO_W))
        else $error("read data present without a read");

    // Master reset and code start. The core must never run through a reset, and it may
    // only start once the clock has been judged usable or the monitor is watching it.

    system_reset_out_drop_a: assert property (!src_any |=> !o_system_reset)                        // [R2]
        else $error("system reset held with no active source");

    run_drop_a: assert property (o_system_reset |=> !o_run)                              // [R9]
        else $error("core kept running through a system reset");

    wait_run_a: assert property ((state_q == ST_WAIT_CLK && clk_ok && !sys_rst_q) |=> o_run) // [R9]
        else $error("core did not start once the clock became valid");

    rel_run_a: assert property ((released && clk_ok) |=> o_run)                          // [R9]
        else $error("core did not start at release with a valid clock");

    run_rise_a: assert property ($rose(o_run) |-> !$past(o_system_reset))                // [R9]
        else $error("core started while the system reset was active");

    run_clock_a: assert property ($rose(o_run) |-> ($past(clk_ok) || $past(i_clock_fail_monitor_enable))) // [R9]
        else $error("core started without a usable clock");

    // Clock-fail monitor. It must stay silent while the reset is held, because the
    // oscillator may legitimately still be starting at that time.

    trap_gate_a: assert property (o_system_reset |=> !o_trap)                            // [R10]
        else $error("trap raised while the system reset was held");

    mon_off_a: assert property (!i_clock_fail_monitor_enable |=> !o_trap)                              // [R10]
        else $error("trap raised with the clock monitor disabled");

    trap_pulse_a: assert property (o_trap |=> !o_trap)                                   // [R11]
        else $error("trap request longer than one cycle");

    fail_flag_a: assert property ((fail_evt && !src_any) |=> osc_q[OSC_FAIL_BIT])        // [R11]
        else $error("clock failure flag not recorded");

    fail_irq_a: assert property (fail_evt |=> ist_q[IRQ_CLK_FAIL])                       // [R11]
        else $error("clock failure event not recorded in interrupt status");

    rel_irq_a: assert property (released |=> ist_q[IRQ_RST_DONE])
        else $error("reset release event not recorded in interrupt status");

    // Status flags record causes and software writes; the next two guard that an active cause sets its flag and that nothing else moves them.

    flag_set_a: assert property ((src_any && !i_src.por) |=> ((rcs_q & $past(src_bits)) == $past(src_bits))) // [R3]
        else $error("active reset source flag not set");

    rcs_hold_a: assert property ((!src_any && !wr_rcs) |=> $stable(rcs_q))                // [R5]
        else $error("reset status changed without a source or a write");

    // Oscillator control: a non power-on reset must keep the running selection, since
    // the oscillator itself keeps running through such a reset.

    nonpor_cur_a: assert property ((src_any && !i_src.por) |=> $stable(o_osc_cur))        // [R15]
        else $error("non power-on reset changed the running oscillator");

    nonpor_new_a: assert property ((src_any && !i_src.por) |=>                            // [R15]
        (osc_q[OSC_NEW_LSB +: 3] == $past(i_initial_osc_select)))
        else $error("non power-on reset did not reload the requested oscillator");

    por_fail_a: assert property (i_src.por |=> !osc_q[OSC_FAIL_BIT])                      // [R15]
        else $error("power-on did not clear the clock failure flag");

    osc_write_a: assert property ((wr_osc && !src_any && !fail_evt) |=>
        (osc_q[OSC_NEW_LSB +: 3] == $past(i_bus.wdata[OSC_NEW_LSB +: 3])))
        else $error("oscillator selection write not stored");

    // Plain register writes outside of resets.

    gen_write_a: assert property ((wr_gen && !src_any) |=> (gen_q == $past(i_bus.wdata)))  // [R13]
        else $error("forced register write not stored");

    gen_hold_a: assert property ((!src_any && !wr_gen) |=> $stable(gen_q))                // [R13]
        else $error("forced register changed without a reset or write");

    rtc_write_a: assert property ((wr_rtc && !i_src.por) |=> (rtc_q == $past(i_bus.wdata))) // [R16]
        else $error("RTC configuration write not stored");

    nvm_write_a: assert property ((wr_nvm && !i_src.por) |=> (nvm_q == $past(i_bus.wdata))) // [R16]
        else $error("NVM control write not stored");

    scratch_write_a: assert property (wr_scratch |=> (scratch_q == $past(i_bus.wdata)))   // [R12]
        else $error("scratch register write not stored");

    msk_write_a: assert property (wr_msk |=> (msk_q == $past(i_bus.wdata[IRQ_W-1:0])))
        else $error("interrupt mask write not stored");

    irq_clear_a: assert property ((wr_ist && !(|evt)) |=>
        (ist_q == ($past(ist_q) & ~$past(i_bus.wdata[IRQ_W-1:0]))))
        else $error("interrupt status write-one-to-clear misbehaved");

    // Read port: data stand for exactly the cycle after the strobe.

    read_stand_a: assert property ((i_bus.rd && i_bus.addr == ADDR_RCS) |=> (o_rdata == $past(rcs_q)))
        else $error("status read returned the wrong word");

    read_unmap_a: assert property ((i_bus.rd && i_bus.addr > ADDR_SEQ) |=> (o_rdata == ZERO_W))
        else $error("unmapped read returned nonzero data");

endmodule : rsc_top

/* File: tb/rsc_partner.sv */
// Far-side model: the reset sources and the oscillator that feed the controller.
// Assumes bench commands arrive by non-blocking assignment at rising edges of i_clk.
`timescale 1ns/1ps
module rsc_partner
    import rsc_pkg::*;
#(
    parameter int OST_CYC = 40
)(
    input  wire logic       i_clk,
    input  wire logic       i_fire,
    input  wire logic [3:0] i_idx,
    input  wire logic [3:0] i_len,
    input  wire logic       i_osc_down,
    output rsc_src_t        o_src,
    output logic            o_clk_valid
);
    int hold_q = 0;
    int ost_q  = 0;

    // Start-up runs apart from reset timing, so the clock may still be bad at release.
    always @(posedge i_clk) begin
        if (i_fire) hold_q <= i_len;
        else if (hold_q > 0) hold_q <= hold_q - 1;
        if (i_osc_down) ost_q <= OST_CYC;
        else if (ost_q > 0) ost_q <= ost_q - 1;
    end

    assign o_src       = (hold_q > 0) ? rsc_src_t'(9'h001 << i_idx) : '0;
    assign o_clk_valid = (ost_q == 0);
endmodule : rsc_partner

/* File: tb/tb_top.sv */
// Self-checking bench for the reset source controller with an integer reference model.
// Assumes rsc_partner supplies the reset source levels and the oscillator valid flag.
`timescale 1ns/1ps
module tb_top
    import rsc_pkg::*;
;
    logic         clk, rst, clock_fail_monitor, fire_s, osc_down, clk_valid;
    logic         sys_rst, run, trap, irq;
    logic [2:0]   initial_osc_select, osc_cur;
    logic [3:0]   idx, len;
    logic [15:0]  rdata;
    logic [31:0]  seed;
    rsc_src_t     src;
    rsc_bus_req_t bus;
    int           errors, total_checks, m_stat, m_osc, w;
    int           m_reg[6];

    rsc_top u_dut (
        .i_clk(clk), .i_reset(rst), .i_src(src), .i_clk_valid(clk_valid),
        .i_clock_fail_monitor_enable(clock_fail_monitor), .i_initial_osc_select(initial_osc_select), .i_bus(bus), .o_system_reset(sys_rst),
        .o_run(run), .o_trap(trap), .o_osc_cur(osc_cur), .o_irq(irq), .o_rdata(rdata)
    );
    rsc_partner u_far (
        .i_clk(clk), .i_fire(fire_s), .i_idx(idx), .i_len(len),
        .i_osc_down(osc_down), .o_src(src), .o_clk_valid(clk_valid)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        bus <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        bus <= '0;
        #1;
        chk("rdata", e, rdata & m);
    endtask : rchk

    // The clock is dropped only once the reset is held, so the monitor cannot trap early.
    task automatic do_reset(input int k, input int n, input logic dn);
        @(posedge clk);
        idx    <= 4'(k);
        len    <= 4'(n);
        fire_s <= 1'b1;
        @(posedge clk);
        fire_s <= 1'b0;
        @(posedge clk);
        osc_down <= dn;
        @(posedge clk);
        osc_down <= 1'b0;
        #1;
        w = 1;
        while (sys_rst === 1'b1 && w < 20) begin
            tick();
            w++;
        end
        chk("reset_len", 16'(n), 16'(w));
        m_reg[4] = 0;
        m_osc    = (k == SRC_POR) ? {initial_osc_select, 1'b0, initial_osc_select} : ((m_osc & 16'h0170) | initial_osc_select);
        m_stat   = (k == SRC_POR) ? 16'h0003 : (m_stat | (1 << k));
        if (k == SRC_POR) begin
            m_reg[2] = 0;
            m_reg[3] = 0;
        end
    endtask : do_reset

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200000;
        errors++;
        finish_test();
    end

    initial begin
        seed = 32'h6627fe65;
        {rst, clock_fail_monitor} = 2'b11;
        {fire_s, osc_down, initial_osc_select, idx, len} = '0;
        bus = '0;
        errors = 0;
        total_checks = 0;
        m_reg = '{default: 0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rchk(ADDR_RCS, 16'hffff, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            wr(ADDR_RCS, seed[15:0]);
            rchk(ADDR_RCS, 16'hffff, seed[15:0]);
            chk("sys_rst", 1'b0, sys_rst);
        end
        wr(ADDR_RCS, 16'h0000);
        wr(4'h9, 16'hffff);
        rchk(4'h9, 16'hffff, 16'h0000);
        wr(ADDR_IRQ_MSK, 16'h0002);
        m_stat = 0;
        for (int i = 1; i <= NSRC; i++) begin
            seed = lfsr(seed);
            wr(ADDR_OSC, {13'h1000, seed[2:0]});
            m_osc = {seed[2:0], 4'h0};
            initial_osc_select <= seed[5:3];
            for (int j = 2; j < 6; j++) begin
                seed = lfsr(seed);
                wr(4'(j), seed[15:0]);
                m_reg[j] = seed[15:0];
            end
            do_reset(i % NSRC, 2 + i % 4, 1'b0);
            tick();
            chk("run", 1'b1, run);
            chk("trap", 1'b0, trap);
            chk("osc_cur", 16'(m_osc[6:4]), 16'(osc_cur));
            rchk(ADDR_RCS, 16'hffff, 16'(m_stat));
            rchk(ADDR_OSC, 16'h0177, 16'(m_osc));
            for (int j = 2; j < 6; j++) rchk(4'(j), 16'hffff, 16'(m_reg[j]));
            rchk(ADDR_SEQ, 16'h000f, 16'h000e);
            rchk(ADDR_IRQ_ST, 16'hffff, 16'h0002);
            chk("irq", 1'b1, irq);
            wr(ADDR_IRQ_ST, 16'h0002);
            tick();
            chk("irq", 1'b0, irq);
            wr(ADDR_RCS, 16'h0000);
            m_stat = 0;
        end
        clock_fail_monitor <= 1'b0;
        wr(ADDR_OSC, 16'h8005);
        do_reset(SRC_WDT, 3, 1'b1);
        w = 0;
        while (clk_valid !== 1'b1 && w < 60) begin
            chk("run", 1'b0, run);
            tick();
            w++;
        end
        w = 0;
        while (run !== 1'b1 && w < 4) begin
            tick();
            w++;
        end
        chk("run", 1'b1, run);
        wr(ADDR_IRQ_MSK, 16'h0000);
        clock_fail_monitor <= 1'b1;
        wr(ADDR_OSC, 16'h8005);
        do_reset(SRC_PIN, 2, 1'b1);
        tick();
        chk("trap", 1'b1, trap);
        chk("osc_cur", 16'h0000, 16'(osc_cur));
        chk("run", 1'b1, run);
        tick();
        chk("trap", 1'b0, trap);
        rchk(ADDR_OSC, 16'h0170, 16'h0100);
        rchk(ADDR_IRQ_ST, 16'h0003, 16'h0003);
        chk("irq", 1'b0, irq);
        finish_test();
    end
endmodule : tb_top
